// ===== logic/sss_setpoint_select.sv
// setpoint source and modulation sensor selection for a lead-lag master
`timescale 1ns/1ps
`default_nettype none
module sss_setpoint_select #(
  parameter int UPD_CYC = sss_pkg::UPD_CYC,
  parameter int PERSIST_UPD = sss_pkg::PERSIST_UPD,
  parameter int STABLE_UPD = sss_pkg::STABLE_UPD
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [4:0] addr_i,
  input wire logic [sss_pkg::TEMP_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [sss_pkg::TEMP_W-1:0] rdata_o,
  input wire logic [sss_pkg::TEMP_W-1:0] primary_modulation_sensor_i,
  input wire logic primary_modulation_sensor_fault_i,
  input wire logic [sss_pkg::LOOP_W-1:0] analog_setpoint_input_i,
  input wire logic analog_setpoint_valid_i,
  input wire logic time_of_day_switch_i,
  input wire logic burner_demand_i,
  input wire logic [sss_pkg::NSLV-1:0] slave_firing_i,
  input wire logic [sss_pkg::NSLV*sss_pkg::TEMP_W-1:0] slave_outlet_i,
  input wire logic [2:0] lead_index_i,
  output logic [sss_pkg::TEMP_W-1:0] control_temp_o,
  output logic control_temp_valid_o,
  output logic [sss_pkg::TEMP_W-1:0] active_setpoint_o,
  output logic analog_in_use_o,
  output logic irq_o
);
  import sss_pkg::*;

  localparam int CNT_W = 16;
  localparam int ACC_W = TEMP_W + 4;

  // overview of the datapath, from inputs to registered results:
  // - a free running divider gives one update pulse every UPD_CYC cycles
  // - every decision below is combinational on the current inputs, except the registered loop revert flag
  // - only the update pulse moves the decisions into the output flops
  // - so the four result outputs hold steady between two update pulses
  // - the register port works on every cycle, not only on updates
  // - writes land at the edge that samples the strobe
  // - reads answer in the following cycle and read zero otherwise
  // - unmapped addresses and the result addresses ignore writes
  // - temperatures are signed words, the none code marks an unset value
  // - the none code is the most negative word and never a valid reading
  // - the loop input is an unsigned code from the current-loop converter
  // - the loop code is checked against a wider band than the 4-20 mA span
  // - codes inside the band but outside the span are clipped, not refused
  //
  // hazards that a user of this block must keep in mind:
  // - a faulty primary sensor with backup off leaves no valid temperature
  // - control_temp_valid_o is then low and control_temp_o reads zero
  // - the reserved backup code behaves exactly like backup off
  // - the lead index is not checked against the firing mask
  // - lead outlet backup follows the lead slave even while it is idle
  // - the average divides by the number of firing slaves only
  // - with nothing firing but demand high the average path is selected and gives zero
  // - the outdoor reset value is computed by software and written here
  // - this block only clamps that value against the minimum
  // - an invalid minimum stops the clamp path and the plain setpoint wins
  // - the interrupt follows the mask that stood before a mask write
  // - so a mask change shows on irq_o one cycle after the write
  //
  // trade-offs taken in this block:
  // - the average uses a plain divider, small because the count is small
  // - the interpolation uses one multiply and one divide per update
  // - both run every cycle, but only the update edge loads the result
  // - that keeps the timing simple at the cost of some area

  // configuration registers
  logic [TEMP_W-1:0] cfg;
  logic [TEMP_W-1:0] sp_norm;
  logic [TEMP_W-1:0] sp_tod;
  logic [TEMP_W-1:0] t20;
  logic [TEMP_W-1:0] t4;
  logic [TEMP_W-1:0] odr_min;
  logic [TEMP_W-1:0] odr_val;
  logic [NEV-1:0] stat;
  logic [NEV-1:0] mask;
  logic [31:0] div_cnt;
  logic upd;
  logic [CNT_W-1:0] bad_cnt;
  logic [CNT_W-1:0] good_cnt;
  logic loop_reverted;

  wire ll_en = cfg[CFG_EN];
  wire sss_backup_t bk = sss_backup_t'(cfg[CFG_BK_LSB +: 2]);
  wire src_analog = cfg[CFG_SRC];
  wire odr_en = cfg[CFG_ODR];

  // divider producing the control update pulse
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || div_cnt == 32'(UPD_CYC - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      upd <= 1'b0;
    end else begin
      upd <= (div_cnt == 32'(UPD_CYC - 1));
    end
  end

  // backup temperature sources from the slave boilers
  // - each slave reports its outlet on its own 16 bit lane
  // - the sum runs as a chain across the lanes, one adder per lane
  // - a lane adds its outlet only while its firing bit is high
  // - the count chain counts the firing lanes alongside the sum
  // - four extra sum bits hold eight full scale readings without wrap
  // - the divisor is forced to one while nothing fires
  // - that keeps the divider defined, the result is zero then
  // - the quotient truncates towards zero like any signed divide
  // - the lead outlet is a plain lane select by the lead index
  // - idle means no demand and no slave firing at all
  // mean of the firing slave outlets and the lead outlet
  logic [ACC_W-1:0] sum_w [0:NSLV];
  logic [3:0] cnt_w [0:NSLV];
  assign sum_w[0] = '0;
  assign cnt_w[0] = '0;
  genvar g;
  generate
    for (g = 0; g < NSLV; g++) begin : g_sum
      wire signed [TEMP_W-1:0] t = slave_outlet_i[g*TEMP_W +: TEMP_W];
      assign sum_w[g+1] = slave_firing_i[g] ?
        sum_w[g] + ACC_W'(t) : sum_w[g];
      assign cnt_w[g+1] = cnt_w[g] + {3'h0, slave_firing_i[g]};
    end
  endgenerate
  wire signed [ACC_W-1:0] sum_s = sum_w[NSLV];
  // divisor never zero, and the divide stays signed throughout
  wire [4:0] avg_den = (cnt_w[NSLV] == 4'h0) ? 5'h01 :
    {1'b0, cnt_w[NSLV]};
  wire signed [ACC_W-1:0] avg_full = sum_s / $signed(avg_den);
  wire [TEMP_W-1:0] avg_t = avg_full[TEMP_W-1:0];
  wire [TEMP_W-1:0] lead_t = slave_outlet_i[lead_index_i*TEMP_W +: TEMP_W];
  wire any_firing = |slave_firing_i;
  wire idle = !burner_demand_i && !any_firing;

  // control temperature choice with backup fallback
  wire use_lead = (bk == SSS_BK_LEAD) || ((bk == SSS_BK_AVG) && idle);
  wire use_avg = (bk == SSS_BK_AVG) && !idle;
  wire [TEMP_W-1:0] next_temp = !primary_modulation_sensor_fault_i ?
    primary_modulation_sensor_i : use_lead ? lead_t :
    use_avg ? avg_t : '0;
  wire next_temp_valid = !primary_modulation_sensor_fault_i ||
    use_lead || use_avg;

  // analog setpoint path, checks first
  // - an endpoint is usable when set and inside the valid window
  // - the two endpoints must also lie at least the minimum span apart
  // - the span is taken with one extra bit so it cannot overflow
  // - the span may be negative, a falling curve is allowed
  // - a bad endpoint raises its event only while analog is chosen
  // - the loop is bad when the converter flags it or it leaves the band
  // - a bad loop alone does not switch to local at once
  // - only a bad loop that persists switches to local
  // endpoint checks for the current-loop curve
  function automatic logic temp_ok(input logic [TEMP_W-1:0] t);
    temp_ok = (t != TEMP_NONE) && ($signed(t) >= $signed(TEMP_MIN)) &&
      ($signed(t) <= $signed(TEMP_MAX));
  endfunction
  wire signed [TEMP_W:0] span = $signed({t20[TEMP_W-1], t20}) -
    $signed({t4[TEMP_W-1], t4});
  wire signed [TEMP_W:0] abs_span = span[TEMP_W] ? -span : span;
  wire endp_bad = !temp_ok(t20) || !temp_ok(t4) ||
    (abs_span < $signed({1'b0, MIN_SPAN}));
  wire loop_bad = !analog_setpoint_valid_i ||
    (analog_setpoint_input_i < LOOP_BAD_LO) ||
    (analog_setpoint_input_i > LOOP_BAD_HI);

  // linear interpolation, input clipped to the 4 to 20 mA span
  wire [LOOP_W-1:0] loop_c = (analog_setpoint_input_i < LOOP_LO) ? LOOP_LO :
    (analog_setpoint_input_i > LOOP_HI) ? LOOP_HI : analog_setpoint_input_i;
  wire signed [LOOP_W:0] num = $signed({1'b0, loop_c - LOOP_LO});
  wire signed [LOOP_W:0] den = $signed({1'b0, LOOP_HI - LOOP_LO});
  wire signed [TEMP_W+LOOP_W+1:0] prod = span * num;
  wire signed [TEMP_W+LOOP_W+1:0] quo = prod / den;
  wire [TEMP_W-1:0] sp_analog = t4 + quo[TEMP_W-1:0];

  // local setpoint: time-of-day choice, outdoor reset and clamp
  wire tod_on = time_of_day_switch_i;
  wire [TEMP_W-1:0] sp_sel = tod_on ? sp_tod : sp_norm;
  wire odr_min_bad = !temp_ok(odr_min);
  wire odr_run = odr_en && !odr_min_bad;
  wire [TEMP_W-1:0] odr_clamped =
    ($signed(odr_val) < $signed(odr_min)) ? odr_min : odr_val;
  wire [TEMP_W-1:0] sp_local = odr_run ? odr_clamped : sp_sel;
  wire analog_ok = src_analog && !endp_bad && !loop_reverted;
  wire [TEMP_W-1:0] next_setpoint = analog_ok ? sp_analog : sp_local;

  // persistence counters, stepped on update pulses only
  // - bad_cnt counts updates with a bad loop and clears on a good one
  // - good_cnt counts updates with a good loop and clears on a bad one
  // - both saturate at their limit so they never wrap
  // - the reverted flag sets on the last bad update of the window
  // - it clears on the last good update of the stable window
  // - a single glitch in either window restarts that window
  // - the flag holds the choice in between, giving a simple hysteresis
  // persistence of a bad loop and return after a stable period
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bad_cnt <= '0;
      good_cnt <= '0;
      loop_reverted <= 1'b0;
    end else if (upd) begin
      bad_cnt <= loop_bad ? ((bad_cnt == CNT_W'(PERSIST_UPD)) ?
        bad_cnt : bad_cnt + 16'h1) : '0;
      good_cnt <= loop_bad ? '0 : ((good_cnt == CNT_W'(STABLE_UPD)) ?
        good_cnt : good_cnt + 16'h1);
      if (loop_bad && bad_cnt >= CNT_W'(PERSIST_UPD - 1)) begin
        loop_reverted <= 1'b1;
      end else if (!loop_bad && good_cnt >= CNT_W'(STABLE_UPD - 1)) begin
        loop_reverted <= 1'b0;
      end
    end
  end

  // alert events, sampled on each update
  wire [NEV-1:0] ev;
  assign ev[EV_SENS] = upd && ll_en && primary_modulation_sensor_fault_i;
  assign ev[EV_ENDP] = upd && src_analog && endp_bad;
  assign ev[EV_ODR] = upd && odr_en && odr_min_bad;
  assign ev[EV_LOOP] = upd && src_analog && loop_reverted;

  // register writes decode
  wire wr_cfg = wr_i && addr_i == ADDR_CFG;
  wire wr_stat = wr_i && addr_i == ADDR_STAT;
  wire [NEV-1:0] next_stat = (stat & ~(wr_stat ? wdata_i[NEV-1:0] : '0)) | ev;

  // configuration storage
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cfg <= '0;
      sp_norm <= TEMP_NONE;
      sp_tod <= TEMP_NONE;
      t20 <= TEMP_NONE;
      t4 <= TEMP_NONE;
      odr_min <= TEMP_NONE;
      odr_val <= '0;
      mask <= '0;
    end else if (wr_i) begin
      if (wr_cfg) cfg <= {11'h000, wdata_i[4:0]};
      if (addr_i == ADDR_SP) sp_norm <= wdata_i;
      if (addr_i == ADDR_TOD_SP) sp_tod <= wdata_i;
      if (addr_i == ADDR_T20) t20 <= wdata_i;
      if (addr_i == ADDR_T4) t4 <= wdata_i;
      if (addr_i == ADDR_ODR_MIN) odr_min <= wdata_i;
      if (addr_i == ADDR_ODR_VAL) odr_val <= wdata_i;
      if (addr_i == ADDR_MASK) mask <= wdata_i[NEV-1:0];
    end
  end

  // sticky status, set wins over clear, and interrupt
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      stat <= '0;
      irq_o <= 1'b0;
    end else begin
      stat <= next_stat;
      irq_o <= |(next_stat & mask);
    end
  end

  // registered results, refreshed each update
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      control_temp_o <= '0;
      control_temp_valid_o <= 1'b0;
      active_setpoint_o <= '0;
      analog_in_use_o <= 1'b0;
    end else if (upd) begin
      control_temp_o <= next_temp;
      control_temp_valid_o <= next_temp_valid;
      active_setpoint_o <= next_setpoint;
      analog_in_use_o <= analog_ok;
    end
  end

  // register map seen by software
  // - 0x00 configuration: enable, backup choice, source, outdoor reset
  // - 0x01 normal setpoint, 0x02 time-of-day setpoint
  // - 0x03 and 0x04 the 20 mA and 4 mA endpoint temperatures
  // - 0x05 outdoor reset minimum, 0x06 outdoor reset computed value
  // - 0x07 sticky status, a one written clears that bit
  // - 0x08 interrupt mask with the same layout as the status
  // - 0x09 to 0x0B read back the registered results and state
  // - a clear and a new event in the same cycle leave the bit set
  // - read data is gated to zero outside the answer cycle
  // read mux
  logic [TEMP_W-1:0] rd_mux;
  always_comb begin
    case (addr_i)
      ADDR_CFG: rd_mux = cfg;
      ADDR_SP: rd_mux = sp_norm;
      ADDR_TOD_SP: rd_mux = sp_tod;
      ADDR_T20: rd_mux = t20;
      ADDR_T4: rd_mux = t4;
      ADDR_ODR_MIN: rd_mux = odr_min;
      ADDR_ODR_VAL: rd_mux = odr_val;
      ADDR_STAT: rd_mux = {12'h000, stat};
      ADDR_MASK: rd_mux = {12'h000, mask};
      ADDR_TEMP: rd_mux = control_temp_o;
      ADDR_SETP: rd_mux = active_setpoint_o;
      ADDR_STATE: rd_mux = {12'h000, irq_o, loop_reverted,
        analog_in_use_o, control_temp_valid_o};
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end
endmodule : sss_setpoint_select
`default_nettype wire

// ===== logic/sss_pkg.sv
// package of constants for the setpoint and sensor selection block
package sss_pkg;
  localparam int TEMP_W = 16;
  localparam int LOOP_W = 12;
  localparam int NSLV = 8;
  localparam logic [TEMP_W-1:0] TEMP_NONE = 16'h8000;
  localparam logic [TEMP_W-1:0] TEMP_MIN = 16'hFE70;
  localparam logic [TEMP_W-1:0] TEMP_MAX = 16'h0E10;
  localparam logic [TEMP_W-1:0] MIN_SPAN = 16'h0020;
  localparam logic [LOOP_W-1:0] LOOP_LO = 12'h199;
  localparam logic [LOOP_W-1:0] LOOP_HI = 12'h7FF;
  localparam logic [LOOP_W-1:0] LOOP_BAD_LO = 12'h180;
  localparam logic [LOOP_W-1:0] LOOP_BAD_HI = 12'h820;
  localparam int CLK_HZ = 40000000;
  localparam int UPD_HZ = 1000;
  localparam int UPD_CYC = CLK_HZ / UPD_HZ;
  localparam int PERSIST_MS = 3000;
  localparam int STABLE_MS = 3000;
  localparam int PERSIST_UPD = PERSIST_MS * UPD_HZ / 1000;
  localparam int STABLE_UPD = STABLE_MS * UPD_HZ / 1000;
  localparam logic [4:0] ADDR_CFG = 5'h00;
  localparam logic [4:0] ADDR_SP = 5'h01;
  localparam logic [4:0] ADDR_TOD_SP = 5'h02;
  localparam logic [4:0] ADDR_T20 = 5'h03;
  localparam logic [4:0] ADDR_T4 = 5'h04;
  localparam logic [4:0] ADDR_ODR_MIN = 5'h05;
  localparam logic [4:0] ADDR_ODR_VAL = 5'h06;
  localparam logic [4:0] ADDR_STAT = 5'h07;
  localparam logic [4:0] ADDR_MASK = 5'h08;
  localparam logic [4:0] ADDR_TEMP = 5'h09;
  localparam logic [4:0] ADDR_SETP = 5'h0A;
  localparam logic [4:0] ADDR_STATE = 5'h0B;
  localparam int CFG_EN = 0;
  localparam int CFG_BK_LSB = 1;
  localparam int CFG_SRC = 3;
  localparam int CFG_ODR = 4;
  localparam int EV_SENS = 0;
  localparam int EV_ENDP = 1;
  localparam int EV_ODR = 2;
  localparam int EV_LOOP = 3;
  localparam int NEV = 4;
  typedef enum logic [1:0] {
    SSS_BK_OFF, SSS_BK_LEAD, SSS_BK_AVG, SSS_BK_RSV
  } sss_backup_t;
endpackage : sss_pkg

// ===== sim/sss_monitor.sv
// port checker for the setpoint and sensor selection block
`timescale 1ns/1ps
`default_nettype none
module sss_monitor #(
  parameter int UPD_CYC = 4,
  parameter int PERSIST_UPD = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [4:0] addr_i,
  input wire logic [sss_pkg::TEMP_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [sss_pkg::TEMP_W-1:0] rdata_o,
  input wire logic [sss_pkg::TEMP_W-1:0] primary_modulation_sensor_i,
  input wire logic primary_modulation_sensor_fault_i,
  input wire logic analog_setpoint_valid_i,
  input wire logic [sss_pkg::TEMP_W-1:0] control_temp_o,
  input wire logic control_temp_valid_o,
  input wire logic analog_in_use_o,
  input wire logic irq_o
);
  import sss_pkg::*;
  localparam int LIM = (PERSIST_UPD + 2) * UPD_CYC;
  logic [4:0] cfg;
  logic [3:0] msk;
  int bad;
  wire logic flt = primary_modulation_sensor_fault_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // shadow copies of the config and mask registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cfg <= 5'h00;
      msk <= 4'h0;
    end else if (wr_i && addr_i == ADDR_CFG) begin
      cfg <= wdata_i[4:0];
    end else if (wr_i && addr_i == ADDR_MASK) begin
      msk <= wdata_i[3:0];
    end
  end
  // run length of an invalid current loop, saturating
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || analog_setpoint_valid_i) bad <= 0;
    else if (bad <= LIM) bad <= bad + 1;
  end
  a_read_gap: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  a_out_hold: assert property ($changed(control_temp_o) |=>
    $stable(control_temp_o) [*3]) else $error("temp changed mid update");
  a_fault_alert: assert property ((cfg[0] && flt && msk[0]) [*8] |-> irq_o)
    else $error("no alert on sensor fault");
  a_no_backup: assert property ((cfg[2:1] == 2'b00 && flt) [*8] |->
    !control_temp_valid_o) else $error("substitute temp used");
  a_primary_used: assert property ((!flt &&
    $stable(primary_modulation_sensor_i)) [*8] |-> control_temp_valid_o &&
    control_temp_o == primary_modulation_sensor_i)
    else $error("primary temp not used");
  a_local_source: assert property ((!cfg[3]) [*8] |-> !analog_in_use_o)
    else $error("analog used while local");
  a_loop_revert: assert property (bad > LIM |-> !analog_in_use_o)
    else $error("no revert on bad loop");
  a_mask_gates: assert property (msk == 4'h0 && $past(msk) == 4'h0 |-> !irq_o)
    else $error("irq with mask clear");
endmodule : sss_monitor
bind sss_setpoint_select sss_monitor #(.UPD_CYC(UPD_CYC),
  .PERSIST_UPD(PERSIST_UPD)) u_mon (.sys_clk_i, .reset_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .primary_modulation_sensor_i,
  .primary_modulation_sensor_fault_i, .analog_setpoint_valid_i,
  .control_temp_o, .control_temp_valid_o, .analog_in_use_o, .irq_o);
`default_nettype wire

// ===== sim/sss_slave_model.sv
// far-side model of eight slave boilers reporting outlet temperatures
`timescale 1ns/1ps
`default_nettype none
module sss_slave_model (
  input wire logic sys_clk_i,
  input wire logic [sss_pkg::TEMP_W-1:0] base_i,
  input wire logic [sss_pkg::NSLV-1:0] fire_i,
  output logic [sss_pkg::NSLV-1:0] slave_firing_o,
  output logic [sss_pkg::NSLV*sss_pkg::TEMP_W-1:0] slave_outlet_o
);
  import sss_pkg::*;
  // each slave reads 0x10 warmer than the one below it
  always_ff @(posedge sys_clk_i) begin
    slave_firing_o <= fire_i;
    for (int k = 0; k < NSLV; k++) begin
      slave_outlet_o[k*TEMP_W +: TEMP_W] <= base_i + (16'(k) << 4);
    end
  end
endmodule : sss_slave_model
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the setpoint and sensor selection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sss_pkg::*;
  localparam logic [7:0] MS [4] = '{8'h01, 8'h81, 8'h07, 8'hF0};
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, flt = 1'b0;
  logic lv = 1'b1, time_of_day_switch = 1'b0, dem = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wd = 16'h0000, prim = 16'h0100, base = 16'h0200;
  logic [15:0] rdv, sp0, sp1;
  logic [11:0] lp = 12'h199;
  logic [7:0] fire = 8'h00;
  logic [2:0] ld = 3'h0;
  wire logic [15:0] rdata, ct, asp;
  wire logic cval, ain, irq;
  wire logic [7:0] sf;
  wire logic [127:0] so;
  int err_total = 0, comparisons = 0;
  sss_slave_model u_sl (.sys_clk_i(clk), .base_i(base), .fire_i(fire),
    .slave_firing_o(sf), .slave_outlet_o(so));
  sss_setpoint_select #(.UPD_CYC(4), .PERSIST_UPD(3), .STABLE_UPD(3)) dut (
    .sys_clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wd),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .primary_modulation_sensor_i(prim),
    .primary_modulation_sensor_fault_i(flt), .analog_setpoint_input_i(lp),
    .analog_setpoint_valid_i(lv), .time_of_day_switch_i(time_of_day_switch),
    .burner_demand_i(dem), .slave_firing_i(sf), .slave_outlet_i(so),
    .lead_index_i(ld), .control_temp_o(ct), .control_temp_valid_o(cval),
    .active_setpoint_o(asp), .analog_in_use_o(ain), .irq_o(irq));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // mean outlet over the firing slaves of the model
  function automatic logic [15:0] exp_avg(logic [15:0] b, logic [7:0] f);
    int s = 0;
    int n = 0;
    for (int k = 0; k < 8; k++) if (f[k]) begin
      s += k;
      n++;
    end
    return b + 16'(s * 16 / n);
  endfunction : exp_avg
  function automatic logic [15:0] rnd_t();
    return 16'h0100 + 16'($urandom_range(0, 2047));
  endfunction : rnd_t
  // watchdog
  initial begin
    #100us;
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    void'($urandom(94850));
    settle(10);
    rst <= 1'b0;
    settle(2);
    chk("temp rst", ct, 16'h0000);
    rd(ADDR_SP, rdv);
    chk("sp rst", rdv, TEMP_NONE);
    rd(5'h1F, rdv);
    chk("unmapped", rdv, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      prim <= rnd_t();
      settle(10);
      chk("primary", ct, prim);
    end
    wr(ADDR_MASK, 16'h000F);
    wr(ADDR_CFG, 16'h0001);
    flt <= 1'b1;
    settle(10);
    chk("no backup", {15'h0, cval}, 16'h0000);
    chk("alert", {15'h0, irq}, 16'h0001);
    rd(ADDR_STAT, rdv);
    chk("stat fault", rdv, 16'h0001);
    wr(ADDR_CFG, 16'h0003);
    base <= rnd_t();
    ld <= 3'($urandom_range(0, 7));
    fire <= 8'hFF;
    dem <= 1'b1;
    settle(12);
    chk("lead", ct, base + (16'(ld) << 4));
    wr(ADDR_CFG, 16'h0005);
    foreach (MS[i]) begin
      fire <= MS[i];
      base <= rnd_t();
      settle(12);
      chk("average", ct, exp_avg(base, fire));
    end
    fire <= 8'h00;
    dem <= 1'b0;
    settle(12);
    chk("idle lead", ct, base + (16'(ld) << 4));
    flt <= 1'b0;
    wr(ADDR_MASK, 16'h0000);
    settle(2);
    chk("masked", {15'h0, irq}, 16'h0000);
    wr(ADDR_STAT, 16'h000F);
    wr(ADDR_MASK, 16'h000F);
    settle(8);
    chk("cleared", {15'h0, irq}, 16'h0000);
    sp0 = rnd_t();
    sp1 = rnd_t();
    wr(ADDR_SP, sp0);
    wr(ADDR_TOD_SP, sp1);
    for (int t = 0; t < 2; t++) begin
      time_of_day_switch <= t[0];
      settle(10);
      chk("tod", asp, t[0] ? sp1 : sp0);
    end
    wr(ADDR_ODR_MIN, 16'h0200);
    wr(ADDR_ODR_VAL, 16'h01F0);
    wr(ADDR_CFG, 16'h0011);
    settle(10);
    chk("odr clamp", asp, 16'h0200);
    wr(ADDR_ODR_VAL, 16'h0220);
    settle(10);
    chk("odr value", asp, 16'h0220);
    wr(ADDR_ODR_MIN, TEMP_NONE);
    time_of_day_switch <= 1'b0;
    settle(10);
    chk("odr off", asp, sp0);
    rd(ADDR_STAT, rdv);
    chk("stat odr", rdv, 16'h0004);
    wr(ADDR_T20, 16'h0300);
    wr(ADDR_T4, 16'h0100);
    wr(ADDR_CFG, 16'h0009);
    wr(ADDR_STAT, 16'h000F);
    for (int j = 0; j < 2; j++) begin
      lp <= j[0] ? LOOP_HI : LOOP_LO;
      settle(10);
      chk("loop", asp, j[0] ? 16'h0300 : 16'h0100);
    end
    wr(ADDR_T4, TEMP_NONE);
    settle(10);
    chk("bad endp", asp, sp0);
    rd(ADDR_STAT, rdv);
    chk("stat endp", rdv, 16'h0002);
    wr(ADDR_T4, 16'h0100);
    settle(8);
    wr(ADDR_STAT, 16'h000F);
    lv <= 1'b0;
    settle(30);
    chk("revert", {15'h0, ain}, 16'h0000);
    rd(ADDR_STAT, rdv);
    chk("stat loop", rdv, 16'h0008);
    lv <= 1'b1;
    settle(30);
    chk("restored", asp, 16'h0300);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
